// file: dv/lcs_charge_checker.sv
// Purpose: Port assertions for the charge sequencer
// Assumes: Bound to lcs_charge_sequencer; sense seen three edges late
// Notes: Commands act one edge after they are taken
`timescale 1ns/10ps
`default_nettype none
module lcs_charge_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Inputs watched
    input wire logic [1:0] cell_count_select,
    input wire logic charge_hold_off,
    input wire lcs_pkg::lcs_sense_type sense_async,
    input wire lcs_pkg::lcs_cmd_type cmd,
    // Outputs watched
    input wire logic precond_current_on,
    input wire logic bulk_current_on,
    input wire logic pwm_enable,
    input wire logic [15:0] float_target_mv,
    input wire logic charging_status_oe,
    input wire logic charge_fault_flag,
    input wire logic charge_state_bit0,
    input wire logic charge_state_bit1,
    input wire logic alarm_lockout
);
    logic [15:0] mv_exp;
    assign mv_exp = cell_count_select == 2'h0 ? lcs_pkg::FLOAT_MV_1 :
        cell_count_select == 2'h1 ? lcs_pkg::FLOAT_MV_2 :
        cell_count_select == 2'h2 ? lcs_pkg::FLOAT_MV_3 : lcs_pkg::FLOAT_MV_4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    status_state_a: assert property (
        charging_status_oe == (charge_state_bit0 | charge_state_bit1))
        else $error("status pin and state bits disagree");
    trickle_state_a: assert property (
        precond_current_on |-> charge_state_bit0 && !charge_state_bit1 && !bulk_current_on)
        else $error("trickle current outside precondition");
    float_sel_a: assert property (
        (clk_en && $stable(cell_count_select))[*4] |=> float_target_mv == $past(mv_exp))
        else $error("float target does not follow cell count");
    overvolt_pwm_a: assert property (
        (clk_en && sense_async.overvoltage_threshold)[*5] |-> !pwm_enable)
        else $error("pwm running in overvoltage");
    clear_cmd_a: assert property (
        cmd.clear_to_zero_cmd && clk_en |=> !charge_fault_flag && !charging_status_oe
        && !precond_current_on && !bulk_current_on) else $error("clear left charge on");
    holdoff_stop_a: assert property (
        (clk_en && charge_hold_off)[*2] |=> !charging_status_oe && !charge_fault_flag)
        else $error("charging during hold-off");
    alarm_lock_a: assert property (
        cmd.alarm_stop_cmd && clk_en && !cmd.clear_to_zero_cmd && !cmd.por_reinit_cmd
        && !charge_hold_off |=> alarm_lockout && !charging_status_oe) else $error("alarm ignored");
    zero_stop_a: assert property (
        cmd.charge_zero_cmd && clk_en |=> !charging_status_oe && !precond_current_on
        && !bulk_current_on) else $error("zero request left charge on");
    reinit_clear_a: assert property (
        cmd.por_reinit_cmd && clk_en |=> !charge_fault_flag && !alarm_lockout
        && !charging_status_oe) else $error("reinit left bits set");
    cover property (charge_state_bit0 && !charge_state_bit1);
    cover property (charge_state_bit0 && charge_state_bit1);
    cover property (alarm_lockout);
endmodule : lcs_charge_checker
bind lcs_charge_sequencer lcs_charge_checker i_chk (.core_clk, .reset_n, .clk_en,
    .cell_count_select, .charge_hold_off, .sense_async, .cmd, .precond_current_on,
    .bulk_current_on, .pwm_enable, .float_target_mv, .charging_status_oe,
    .charge_fault_flag, .charge_state_bit0, .charge_state_bit1, .alarm_lockout);
`default_nettype wire

// file: dv/lcs_charge_sequencer_tb_top.sv
// Purpose: Self-checking bench for the charge sequencer
// Assumes: Lithium kind and clock enable tied active
// Notes: Model state code 0 off, 1 precondition, 2 bulk, 3 top-off
`timescale 1ns/10ps
`default_nettype none
module lcs_charge_sequencer_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic timer_tick = 1'b0;
    logic [1:0] cell_count_select = 2'h0;
    logic charge_hold_off = 1'b0;
    lcs_pkg::lcs_sense_type sense_async = '0;
    lcs_pkg::lcs_cmd_type cmd;
    logic send = 1'b0;
    logic [2:0] op = 3'h0;
    logic [3:0] alarm_bits = 4'h0;
    logic precond_current_on, bulk_current_on, pwm_enable, charging_status_n;
    logic charging_status_oe, charge_fault_flag, charge_state_bit0, charge_state_bit1;
    logic alarm_lockout, charge_hold_off_flag;
    logic [15:0] float_target_mv;
    int fail_count = 0;
    int total_checks = 0;
    int q = int'(lcs_pkg::QUARTER_TICKS);
    int mv_tab [4] = '{4200, 8400, 12600, 16800};
    always #50 core_clk = ~core_clk;
    lcs_smbus_model i_smb (.core_clk, .reset_n, .send, .op, .alarm_bits, .cmd);
    lcs_charge_sequencer i_dut (.core_clk, .reset_n, .clk_en(1'b1), .timer_tick,
        .kind_select_high(1'b0), .cell_count_select, .charge_hold_off, .sense_async, .cmd,
        .precond_current_on, .bulk_current_on, .pwm_enable, .float_target_mv,
        .charging_status_n, .charging_status_oe, .charge_fault_flag, .charge_state_bit0,
        .charge_state_bit1, .alarm_lockout, .charge_hold_off_flag);
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic look(input int st);
        @(negedge core_clk);
        check(16'({charging_status_oe, charge_state_bit1, charge_state_bit0,
            precond_current_on, bulk_current_on}), 16'({st != 0, 2'(st), st == 1, st > 1}));
        @(posedge core_clk);
    endtask : look
    task automatic smb(input logic [2:0] o, input logic [3:0] bits);
        send <= 1'b1;
        op <= o;
        alarm_bits <= bits;
        cyc(1);
        send <= 1'b0;
        cyc(2);
    endtask : smb
    task automatic ticks(input int n);
        repeat (n)
        begin
            timer_tick <= 1'b1;
            cyc(1);
            timer_tick <= 1'b0;
            cyc(1);
        end
    endtask : ticks
    initial
    begin
        cyc(80000);
        fail_count++;
        summarize();
    end
    initial
    begin
        void'($urandom(87));
        cyc(20);
        reset_n <= 1'b1;
        // Supply first, so a later hold-off is not masked by a loss event
        sense_async.supply_present_sense <= 1'b1;
        foreach (mv_tab[i])
        begin
            cell_count_select <= 2'(i);
            cyc(5);
            @(negedge core_clk);
            check(float_target_mv, 16'(mv_tab[i]));
            @(posedge core_clk);
        end
        cell_count_select <= 2'($urandom_range(3));
        charge_hold_off <= 1'b1;
        sense_async.supply_present_sense <= 1'b1;
        sense_async.below_recharge <= 1'b1;
        cyc(5);
        look(0);
        check(charge_hold_off_flag, 16'h0001);
        charge_hold_off <= 1'b0;
        cyc(5);
        look(1);
        check(charging_status_n, 16'h0000);
        sense_async.below_recharge <= 1'b0;
        sense_async.bulk_threshold <= 1'b1;
        cyc(5);
        look(2);
        sense_async.overvoltage_threshold <= 1'b1;
        sense_async.recharge_threshold <= 1'b1;
        cyc(6);
        @(negedge core_clk);
        check(16'({pwm_enable, charge_fault_flag}), 16'h0000);
        look(2);
        sense_async.overvoltage_threshold <= 1'b0;
        cyc(6);
        @(negedge core_clk);
        check(pwm_enable, 16'h0000);
        @(posedge core_clk);
        sense_async.recharge_threshold <= 1'b0;
        cyc(6);
        @(negedge core_clk);
        check(16'({pwm_enable, charge_hold_off_flag}), 16'h0002);
        @(posedge core_clk);
        sense_async.c5_reached <= 1'b1;
        cyc(5);
        look(3);
        ticks(q - 2);
        look(3);
        ticks(4);
        look(0);
        sense_async.c5_reached <= 1'b0;
        sense_async.bulk_threshold <= 1'b0;
        sense_async.below_recharge <= 1'b1;
        cyc(5);
        look(1);
        sense_async.below_recharge <= 1'b0;
        smb(3'h4, 4'h0);
        look(1);
        smb(3'h4, 4'($urandom_range(15, 1)));
        look(0);
        check(alarm_lockout, 16'h0001);
        smb(3'h2, 4'h0);
        look(1);
        check(alarm_lockout, 16'h0000);
        smb(3'h3, 4'h0);
        look(0);
        smb(3'h2, 4'h0);
        ticks(q + 2);
        look(0);
        check(charge_fault_flag, 16'h0001);
        sense_async.supply_present_sense <= 1'b0;
        cyc(5);
        sense_async.supply_present_sense <= 1'b1;
        cyc(5);
        look(0);
        check(charge_fault_flag, 16'h0001);
        smb(3'h0, 4'h0);
        look(0);
        check(charge_fault_flag, 16'h0000);
        smb(3'h2, 4'h0);
        sense_async.thermistor_hot <= 1'b1;
        cyc(5);
        @(negedge core_clk);
        check(16'({charge_fault_flag, precond_current_on, charge_state_bit0}), 16'h0005);
        sense_async.thermistor_hot <= 1'b0;
        cyc(5);
        look(1);
        check(charge_fault_flag, 16'h0000);
        smb(3'h1, 4'h0);
        look(0);
        check(16'({charge_fault_flag, alarm_lockout}), 16'h0000);
        summarize();
    end
endmodule : lcs_charge_sequencer_tb_top
`default_nettype wire

// file: dv/lcs_smbus_model.sv
// Purpose: Host and smart battery side, turns requests into command pulses
// Assumes: Requests are one-cycle pulses on core_clk
// Notes: Alarm word only stops charge when a stopping bit is set
`timescale 1ns/10ps
`default_nettype none
module lcs_smbus_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Request from bench
    input wire logic send,
    input wire logic [2:0] op,
    input wire logic [3:0] alarm_bits,
    // Command pulses
    output lcs_pkg::lcs_cmd_type cmd
);
    lcs_pkg::lcs_cmd_type next_cmd;
    assign next_cmd.clear_to_zero_cmd = send && op == 3'h0;
    assign next_cmd.por_reinit_cmd = send && op == 3'h1;
    assign next_cmd.charge_nonzero_cmd = send && op == 3'h2;
    assign next_cmd.charge_zero_cmd = send && op == 3'h3;
    assign next_cmd.alarm_stop_cmd = send && op == 3'h4 && |alarm_bits;
    always_ff @(posedge core_clk)
    begin
        cmd <= reset_n ? next_cmd : '0;
    end
endmodule : lcs_smbus_model
`default_nettype wire

// file: hdl/lcs_charge_sequencer.sv
// Purpose: Standard lithium charge-cycle state controller
// Assumes: Analog comparators give levels; SMBus decoder gives pulses
// Notes: Sense and kind pins are synchronised here; commands arrive on core_clk
`timescale 1ns/10ps
`default_nettype none
module lcs_charge_sequencer (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic timer_tick,
    // Configuration pins
    input wire logic kind_select_high,
    input wire logic [1:0] cell_count_select,
    input wire logic charge_hold_off,
    // Analog sense levels
    input wire lcs_pkg::lcs_sense_type sense_async,
    // SMBus command pulses
    input wire lcs_pkg::lcs_cmd_type cmd,
    // Charge outputs
    output logic precond_current_on,
    output logic bulk_current_on,
    output logic pwm_enable,
    output logic [15:0] float_target_mv,
    // Status outputs
    output logic charging_status_n,
    output logic charging_status_oe,
    output logic charge_fault_flag,
    output logic charge_state_bit0,
    output logic charge_state_bit1,
    output logic alarm_lockout,
    output logic charge_hold_off_flag
);
    lcs_pkg::lcs_sense_type s;
    lcs_pkg::lcs_state_type state, next_state;
    logic shutdown_last, overvolt_stop, hold_off_clear;
    logic kind_sync, present_last;

    lcs_sync #(.W(12)) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in({kind_select_high, sense_async}),
        .sync_out({kind_sync, s})
    );

    // Qualification terms
    wire lithium_mode = !kind_sync;
    wire battery_present = !s.thermistor_over_range;
    wire temp_ok = !s.thermistor_hot || s.thermistor_under_range;
    wire hot_pause = s.thermistor_hot && !s.thermistor_under_range;
    wire hold_off = charge_hold_off && !hold_off_clear;
    wire loss_event = !s.supply_present_sense || s.thermistor_over_range
        || s.shutdown_input || s.undervoltage_lockout || cmd.por_reinit_cmd;
    wire shutdown_toggle = s.shutdown_input != shutdown_last;
    wire removed_replaced = battery_present && !present_last;
    wire base_ok = s.supply_present_sense && !s.undervoltage_lockout
        && !s.shutdown_input && battery_present && !hold_off;
    wire start_auto = base_ok && s.below_recharge && temp_ok && lithium_mode;
    wire start_req = base_ok && cmd.charge_nonzero_cmd;
    wire stop_cmd = cmd.clear_to_zero_cmd || hold_off;
    wire charging = (state == lcs_pkg::LCS_PRECOND) || (state == lcs_pkg::LCS_BULK)
        || (state == lcs_pkg::LCS_TOPOFF);
    wire timers_run = !hot_pause;

    wire pre_clear = (state != lcs_pkg::LCS_PRECOND);
    wire bulk_clear = (state != lcs_pkg::LCS_BULK);
    wire top_clear = (state != lcs_pkg::LCS_TOPOFF);
    logic pre_done, bulk_done, top_done;

    lcs_timer u_pre (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .tick(timer_tick),
        .clear(pre_clear), .run(timers_run), .terminal(lcs_pkg::QUARTER_TICKS),
        .done(pre_done)
    );
    lcs_timer u_bulk (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .tick(timer_tick),
        .clear(bulk_clear), .run(timers_run), .terminal(lcs_pkg::BULK_TICKS),
        .done(bulk_done)
    );
    lcs_timer u_top (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .tick(timer_tick),
        .clear(top_clear), .run(timers_run), .terminal(lcs_pkg::QUARTER_TICKS),
        .done(top_done)
    );

    // Fault stays latched across supply loss; other releases clear it
    wire fault_release = cmd.clear_to_zero_cmd || cmd.por_reinit_cmd
        || shutdown_toggle || removed_replaced;

    always_comb
    begin
        next_state = state;
        unique case (state)
            lcs_pkg::LCS_OFF, lcs_pkg::LCS_FULL, lcs_pkg::LCS_LOCKED:
            begin
                if (start_auto || start_req)
                    next_state = s.bulk_threshold ? lcs_pkg::LCS_BULK
                        : lcs_pkg::LCS_PRECOND;
            end
            lcs_pkg::LCS_PRECOND:
            begin
                if (s.bulk_threshold)
                    next_state = lcs_pkg::LCS_BULK;
                else if (pre_done)
                    next_state = lcs_pkg::LCS_FAULT;
            end
            lcs_pkg::LCS_BULK:
            begin
                if (s.c5_reached)
                    next_state = lcs_pkg::LCS_TOPOFF;
                else if (bulk_done)
                    next_state = lcs_pkg::LCS_FAULT;
            end
            lcs_pkg::LCS_TOPOFF:
            begin
                if (top_done)
                    next_state = lcs_pkg::LCS_FULL;
            end
            lcs_pkg::LCS_FAULT:
            begin
                if (fault_release)
                    next_state = lcs_pkg::LCS_OFF;
            end
        endcase
        // Overriding stops, lowest priority first
        if (charging && cmd.charge_zero_cmd)
            next_state = lcs_pkg::LCS_OFF;
        if (cmd.alarm_stop_cmd && state != lcs_pkg::LCS_FAULT)
            next_state = lcs_pkg::LCS_LOCKED;
        if (stop_cmd && state != lcs_pkg::LCS_LOCKED)
            next_state = lcs_pkg::LCS_OFF;
        if (loss_event && !(state == lcs_pkg::LCS_FAULT && !fault_release
            && battery_present && !s.shutdown_input && !cmd.por_reinit_cmd))
            next_state = lcs_pkg::LCS_OFF;
    end

    // Float target by cell count
    wire [15:0] next_float = (cell_count_select == 2'h0) ? lcs_pkg::FLOAT_MV_1
        : (cell_count_select == 2'h1) ? lcs_pkg::FLOAT_MV_2
        : (cell_count_select == 2'h2) ? lcs_pkg::FLOAT_MV_3 : lcs_pkg::FLOAT_MV_4;
    wire [1:0] next_code = (next_state == lcs_pkg::LCS_PRECOND) ? lcs_pkg::STATE_PRE_CODE
        : (next_state == lcs_pkg::LCS_BULK) ? lcs_pkg::STATE_BULK_CODE
        : (next_state == lcs_pkg::LCS_TOPOFF) ? lcs_pkg::STATE_TOP_CODE
        : lcs_pkg::STATE_IDLE_CODE;
    wire next_charging = (next_state == lcs_pkg::LCS_PRECOND)
        || (next_state == lcs_pkg::LCS_BULK) || (next_state == lcs_pkg::LCS_TOPOFF);
    wire next_overvolt = s.overvoltage_threshold ? 1'b1
        : (s.recharge_threshold ? overvolt_stop : 1'b0);
    wire next_fault = (next_state == lcs_pkg::LCS_FAULT)
        || (next_charging && hot_pause);
    wire next_alarm = (next_state == lcs_pkg::LCS_LOCKED)
        || (alarm_lockout && !loss_event && !start_req);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state <= lcs_pkg::LCS_OFF;
            shutdown_last <= 1'b0;
            present_last <= 1'b0;
            overvolt_stop <= 1'b0;
            hold_off_clear <= 1'b0;
            precond_current_on <= 1'b0;
            bulk_current_on <= 1'b0;
            pwm_enable <= 1'b0;
            float_target_mv <= lcs_pkg::FLOAT_MV_1;
            charging_status_n <= 1'b1;
            charging_status_oe <= 1'b0;
            charge_fault_flag <= 1'b0;
            charge_state_bit0 <= 1'b0;
            charge_state_bit1 <= 1'b0;
            alarm_lockout <= 1'b0;
            charge_hold_off_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            shutdown_last <= s.shutdown_input;
            present_last <= battery_present;
            overvolt_stop <= next_overvolt;
            hold_off_clear <= loss_event ? 1'b1 : (charge_hold_off ? hold_off_clear : 1'b0);
            precond_current_on <= (next_state == lcs_pkg::LCS_PRECOND) && !hot_pause;
            bulk_current_on <= ((next_state == lcs_pkg::LCS_BULK)
                || (next_state == lcs_pkg::LCS_TOPOFF)) && !hot_pause;
            pwm_enable <= next_charging && !hot_pause && !next_overvolt;
            float_target_mv <= next_float;
            charging_status_n <= 1'b0; // Output value when driven
            charging_status_oe <= next_charging;
            charge_fault_flag <= next_fault;
            {charge_state_bit1, charge_state_bit0} <= next_code;
            alarm_lockout <= next_alarm;
            charge_hold_off_flag <= hold_off;
        end
    end
endmodule : lcs_charge_sequencer
`default_nettype wire

// file: hdl/lcs_pkg.sv
// Purpose: Shared types and constants for the lithium charge sequencer
// Assumes: 10 MHz core clock; timers count an external timebase tick
// Notes: Float targets in millivolts, one per cell-count setting
package lcs_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    // Bulk terminal count in ticks; quarter timers use one fourth
    localparam logic [19:0] BULK_TICKS = 20'h0e100;
    localparam logic [19:0] QUARTER_TICKS = BULK_TICKS >> 2;
    localparam logic [4:0] FLOAT_1CELL_MV_DIV = 5'h00;
    localparam logic [15:0] FLOAT_MV_1 = 16'h1068;
    localparam logic [15:0] FLOAT_MV_2 = 16'h20d0;
    localparam logic [15:0] FLOAT_MV_3 = 16'h3138;
    localparam logic [15:0] FLOAT_MV_4 = 16'h41a0;
    localparam logic [1:0] STATE_IDLE_CODE = 2'h0;
    localparam logic [1:0] STATE_PRE_CODE = 2'h1;
    localparam logic [1:0] STATE_BULK_CODE = 2'h2;
    localparam logic [1:0] STATE_TOP_CODE = 2'h3;

    typedef enum {
        LCS_OFF, LCS_PRECOND, LCS_BULK, LCS_TOPOFF, LCS_FULL, LCS_FAULT, LCS_LOCKED
    } lcs_state_type;

    // Comparator and sense levels from the analog front end
    typedef struct packed {
        logic supply_present_sense;
        logic undervoltage_lockout;
        logic shutdown_input;
        logic thermistor_over_range;
        logic thermistor_hot;
        logic thermistor_under_range;
        logic below_recharge;
        logic bulk_threshold;
        logic recharge_threshold;
        logic overvoltage_threshold;
        logic c5_reached;
    } lcs_sense_type;

    // Decoded SMBus command events, one-cycle pulses
    typedef struct packed {
        logic clear_to_zero_cmd;
        logic por_reinit_cmd;
        logic charge_nonzero_cmd;
        logic charge_zero_cmd;
        logic alarm_stop_cmd;
    } lcs_cmd_type;
endpackage : lcs_pkg

// file: hdl/lcs_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of levels
// Assumes: Inputs asynchronous to core_clk
// Notes: First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module lcs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : lcs_sync
`default_nettype wire

// file: hdl/lcs_timer.sv
// Purpose: Tick counter with clear, run and terminal-count flag
// Assumes: tick is a one-cycle timebase pulse
// Notes: Holds its count while run is low (pause)
`timescale 1ns/10ps
`default_nettype none
module lcs_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Control
    input wire logic tick,
    input wire logic clear,
    input wire logic run,
    input wire logic [19:0] terminal,
    // Status
    output logic done
);
    logic [19:0] count;
    wire reached = (count >= terminal);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            count <= 20'h00000;
        end
        else if (clk_en)
        begin
            if (clear)
                count <= 20'h00000;
            else if (run && tick && !reached)
                count <= count + 20'h00001;
        end
    end

    assign done = reached && run && !clear;
endmodule : lcs_timer
`default_nettype wire
